// ==== core/iarp_regs.svh ====
// Register offsets, field codes and timing constants of the indexed auto-run positioner.
`ifndef IARP_REGS_SVH
`define IARP_REGS_SVH
`define IARP_AW 12
`define IARP_DW 16
`define IARP_OFS_CTRL_MODE 12'h101
`define IARP_OFS_POS_MODE 12'h121
`define IARP_OFS_ACCEL 12'h122
`define IARP_OFS_DECEL 12'h123
`define IARP_OFS_SCURVE 12'h124
`define IARP_OFS_GEAR_NUM 12'h12c
`define IARP_OFS_GEAR_DEN 12'h12d
`define IARP_OFS_HOME_MODE 12'h12f
`define IARP_OFS_HOME_TURNS 12'h132
`define IARP_OFS_HOME_PULSES 12'h133
`define IARP_OFS_OUT_MODE 12'h22c
`define IARP_OFS_HOLD_DELAY 12'h22d
`define IARP_OFS_SERVO_EN 12'h233
`define IARP_OFS_POS_BASE 12'h10f
`define IARP_OFS_SPEED_BASE 12'h224
`define IARP_OFS_DWELL_BASE 12'h234
`define IARP_OFS_IRQ_STATUS 12'h300
`define IARP_OFS_IRQ_ENABLE 12'h301
`define IARP_OFS_IRQ_CLEAR 12'h302
`define IARP_OFS_STATE 12'h303
`define IARP_OFS_GP_OUT 12'h304
`define IARP_CTRL_PR_FWD 16'h0001
`define IARP_CTRL_PR_REV 16'h0101
`define IARP_POS_AUTO_ABS 16'h0005
`define IARP_POS_AUTO_INC 16'h0006
`define IARP_HOME_FWD 16'h0202
`define IARP_HOME_REV 16'h0203
`define IARP_TURN_PULSES 32'h00002710
`define IARP_CODE_ALARM 5'h00
`define IARP_CODE_READY 5'h01
`define IARP_CODE_HOMING 5'h02
`define IARP_CODE_HOMED 5'h03
`define IARP_CODE_CHANGE 5'h04
`define IARP_CODE_INDEX_BASE 5'h05
`define IARP_TICK_MS 4
`define IARP_CLK_KHZ 100000
`endif

// ==== core/iarp_pkg.sv ====
// Types shared by the indexed auto-run positioner.
package iarp_pkg;
	typedef enum logic [5:0] {
		IARP_ALARM = 6'b000001,
		IARP_READY = 6'b000010,
		IARP_HOMING = 6'b000100,
		IARP_HOMED = 6'b001000,
		IARP_CHANGE = 6'b010000,
		IARP_INPOS = 6'b100000
	} iarp_state_t;
	typedef enum logic [2:0] {
		IARP_EV_ALARM = 3'b001,
		IARP_EV_HOMED = 3'b010,
		IARP_EV_INPOS = 3'b100
	} iarp_event_t;
endpackage

// ==== core/iarp_positioner.sv ====
// Indexed auto-run positioner: settings, index table, sequencer and combination status output.
// Contract
// - Control mode 001 is register position mode forward torque, 101 reversed torque.
// - Position mode 5 runs continuously absolute, 6 runs continuously incremental.
// - Configured acceleration and deceleration times apply to the motion steps.
// - Smoothing setting zero disables shaping and ignores acceleration and deceleration times.
// - Position commands are scaled by gear numerator divided by gear denominator.
// - Homing mode 202 homes forward, 203 reverse, when mode inputs read 0,1.
// - Homing offset equals offset turns times 10000 plus offset pulses.
// - Output mode 0 drives general outputs, 1 drives the combined status code.
// - In combination mode the code holds a programmed delay in 4 ms units.
// - An index point with zero dwell time is skipped by the sequence.
// - Travel limits are normally closed contacts; an open contact is an active limit.
// - Emergency stop is a normally closed contact; open means stop request.
// - During an index change the combination lines show code 00100.
// - Index point n in position shows code n plus 5.
// - Code is 0 on alarm, 1 ready, 2 homing, 3 homing complete.
`timescale 1ns/1ns
`include "iarp_regs.svh"
module iarp_positioner #(
	parameter int TICK_CYCLES = `IARP_CLK_KHZ * `IARP_TICK_MS,
	parameter int POINTS = 8
) (
	input wire logic CLK_IN, // 100 MHz clock
	input wire logic RST_IN, // asynchronous reset, active high
	input wire logic [`IARP_AW-1:0] ADDR_IN, // register address
	input wire logic [`IARP_DW-1:0] WR_DATA_IN, // register write data
	input wire logic WR_IN, // write strobe
	input wire logic RD_IN, // read strobe
	output logic [`IARP_DW-1:0] RD_DATA_OUT, // read data, cycle after strobe
	input wire logic SERVO_ON_IN, // servo on input
	input wire logic AUTO_RUN_IN, // auto run input
	input wire logic INDEX_INC_IN, // step up input
	input wire logic INDEX_DEC_IN, // step down input
	input wire logic INDEX_RET_IN, // return to first live index point input
	input wire logic HOMING_TRIGGER_IN, // homing trigger input
	input wire logic HOME_SENSOR_IN, // reference home sensor
	input wire logic MODE_SEL0_IN, // mode select bit 0
	input wire logic MODE_SEL1_IN, // mode select bit 1
	input wire logic FWD_LIMIT_NC_IN, // forward limit, high while closed
	input wire logic REV_LIMIT_NC_IN, // reverse limit, high while closed
	input wire logic ESTOP_NC_IN, // emergency stop, high while closed
	input wire logic MOVE_DONE_IN, // motion core reports command complete
	output logic MOVE_START_OUT, // one-cycle start of a motion step
	output logic [31:0] CMD_POS_OUT, // geared position target
	output logic [15:0] CMD_SPEED_OUT, // speed of the step
	output logic [15:0] ACCEL_OUT, // effective acceleration time
	output logic [15:0] DECEL_OUT, // effective deceleration time
	output logic SHAPING_EN_OUT, // acceleration shaping active
	output logic TORQUE_REV_OUT, // reversed torque direction
	output logic HOME_DIR_REV_OUT, // homing runs in reverse
	output logic [31:0] HOME_OFFSET_OUT, // total homing offset in pulses
	output logic [4:0] STATUS_LINES_OUT, // output lines 0 to 4
	output logic IRQ_OUT // interrupt, high while enabled status set
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int PW = $clog2(POINTS);
	if (TICK_CYCLES < 1 || POINTS != 8) begin : bad_param
		$error("iarp_positioner: unsupported parameter values");
	end

	logic [15:0] ctrl_mode_reg, pos_mode_reg, accel_reg, decel_reg, scurve_reg;
	logic [15:0] gear_num_reg, gear_den_reg, home_mode_reg, turns_reg, pulses_reg;
	logic [15:0] out_mode_reg, hold_delay_reg, servo_en_reg, gp_reg;
	logic [15:0] pos_lo_reg [POINTS];
	logic [15:0] pos_hi_reg [POINTS];
	logic [15:0] speed_reg [POINTS];
	logic [15:0] dwell_reg [POINTS];
	logic [2:0] irq_status_reg, irq_enable_reg, irq_set;
	iarp_pkg::iarp_state_t state_reg, state_next;
	logic [PW-1:0] ptr_reg, ptr_next;
	logic [31:0] target_reg;
	logic [TW-1:0] tick_cnt_reg;
	logic tick;
	logic [15:0] dwell_cnt_reg, hold_cnt_reg;
	logic [4:0] code;
	logic auto_prev_reg, inc_prev_reg, dec_prev_reg, ret_prev_reg, home_prev_reg, sensor_prev_reg;
	logic auto_rise, inc_rise, dec_rise, ret_rise, home_rise, sensor_rise;
	logic fault, ready, mode_ok, home_ok, go_next, start_move;
	logic [`IARP_DW-1:0] rd_value;

	// Next index point in the given direction whose dwell time is nonzero.
	function automatic logic [PW-1:0] find_point(input logic [PW-1:0] from, input logic down,
			input logic incl, input logic [POINTS-1:0] live);
		logic [PW-1:0] p;
		logic found;
		p = from;
		found = 1'b0;
		find_point = from;
		for (int i = 0; i < POINTS; i++) begin
			if (!(i == 0 && !incl)) begin
				if (!found && live[p]) begin
					find_point = p;
					found = 1'b1;
				end
			end
			p = down ? PW'(p - 1'b1) : PW'(p + 1'b1);
		end
		if (!incl && !found && live[from]) begin
			find_point = from;
		end
	endfunction

	// Position scaled by the gear ratio; a zero denominator passes the position unscaled.
	function automatic logic [31:0] gear_scale(input logic [31:0] pos, input logic [15:0] num,
			input logic [15:0] den);
		logic [47:0] prod;
		prod = pos * num;
		gear_scale = (den == 16'h0000) ? pos : 32'(prod / den);
	endfunction

	logic [POINTS-1:0] live;
	always_comb begin
		for (int i = 0; i < POINTS; i++) begin
			live[i] = (dwell_reg[i] != 16'h0000);
		end
	end

	// Register writes.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ctrl_mode_reg <= `IARP_CTRL_PR_FWD;
			pos_mode_reg <= `IARP_POS_AUTO_ABS;
			accel_reg <= 16'h0000;
			decel_reg <= 16'h0000;
			scurve_reg <= 16'h0000;
			gear_num_reg <= 16'h0001;
			gear_den_reg <= 16'h0001;
			home_mode_reg <= `IARP_HOME_FWD;
			turns_reg <= 16'h0000;
			pulses_reg <= 16'h0000;
			out_mode_reg <= 16'h0001;
			hold_delay_reg <= 16'h0000;
			servo_en_reg <= 16'h0000;
			gp_reg <= 16'h0000;
			irq_enable_reg <= 3'h0;
		end else if (WR_IN) begin
			case (ADDR_IN)
				`IARP_OFS_CTRL_MODE: ctrl_mode_reg <= WR_DATA_IN;
				`IARP_OFS_POS_MODE: pos_mode_reg <= WR_DATA_IN;
				`IARP_OFS_ACCEL: accel_reg <= WR_DATA_IN;
				`IARP_OFS_DECEL: decel_reg <= WR_DATA_IN;
				`IARP_OFS_SCURVE: scurve_reg <= WR_DATA_IN;
				`IARP_OFS_GEAR_NUM: gear_num_reg <= WR_DATA_IN;
				`IARP_OFS_GEAR_DEN: gear_den_reg <= WR_DATA_IN;
				`IARP_OFS_HOME_MODE: home_mode_reg <= WR_DATA_IN;
				`IARP_OFS_HOME_TURNS: turns_reg <= WR_DATA_IN;
				`IARP_OFS_HOME_PULSES: pulses_reg <= WR_DATA_IN;
				`IARP_OFS_OUT_MODE: out_mode_reg <= WR_DATA_IN;
				`IARP_OFS_HOLD_DELAY: hold_delay_reg <= WR_DATA_IN;
				`IARP_OFS_SERVO_EN: servo_en_reg <= WR_DATA_IN;
				`IARP_OFS_GP_OUT: gp_reg <= WR_DATA_IN;
				`IARP_OFS_IRQ_ENABLE: irq_enable_reg <= WR_DATA_IN[2:0];
				default: ;
			endcase
		end
	end

	// Index table: position low and high words, speed and dwell time per point.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			for (int i = 0; i < POINTS; i++) begin
				pos_lo_reg[i] <= 16'h0000;
				pos_hi_reg[i] <= 16'h0000;
				speed_reg[i] <= 16'h0000;
				dwell_reg[i] <= 16'h0000;
			end
		end else if (WR_IN) begin
			for (int i = 0; i < POINTS; i++) begin
				if (ADDR_IN == `IARP_AW'(`IARP_OFS_POS_BASE + 2 * i)) begin
					pos_lo_reg[i] <= WR_DATA_IN;
				end
				if (ADDR_IN == `IARP_AW'(`IARP_OFS_POS_BASE + 2 * i + 1)) begin
					pos_hi_reg[i] <= WR_DATA_IN;
				end
				if (ADDR_IN == `IARP_AW'(`IARP_OFS_SPEED_BASE + i)) begin
					speed_reg[i] <= WR_DATA_IN;
				end
				if (ADDR_IN == `IARP_AW'(`IARP_OFS_DWELL_BASE + i)) begin
					dwell_reg[i] <= WR_DATA_IN;
				end
			end
		end
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		rd_value = '0;
		case (ADDR_IN)
			`IARP_OFS_CTRL_MODE: rd_value = ctrl_mode_reg;
			`IARP_OFS_POS_MODE: rd_value = pos_mode_reg;
			`IARP_OFS_ACCEL: rd_value = accel_reg;
			`IARP_OFS_DECEL: rd_value = decel_reg;
			`IARP_OFS_SCURVE: rd_value = scurve_reg;
			`IARP_OFS_GEAR_NUM: rd_value = gear_num_reg;
			`IARP_OFS_GEAR_DEN: rd_value = gear_den_reg;
			`IARP_OFS_HOME_MODE: rd_value = home_mode_reg;
			`IARP_OFS_HOME_TURNS: rd_value = turns_reg;
			`IARP_OFS_HOME_PULSES: rd_value = pulses_reg;
			`IARP_OFS_OUT_MODE: rd_value = out_mode_reg;
			`IARP_OFS_HOLD_DELAY: rd_value = hold_delay_reg;
			`IARP_OFS_SERVO_EN: rd_value = servo_en_reg;
			`IARP_OFS_GP_OUT: rd_value = gp_reg;
			`IARP_OFS_IRQ_STATUS: rd_value = {13'h0000, irq_status_reg};
			`IARP_OFS_IRQ_ENABLE: rd_value = {13'h0000, irq_enable_reg};
			`IARP_OFS_STATE: rd_value = {2'b00, ptr_reg, state_reg, code};
			default: begin
				for (int i = 0; i < POINTS; i++) begin
					if (ADDR_IN == `IARP_AW'(`IARP_OFS_POS_BASE + 2 * i)) rd_value = pos_lo_reg[i];
					if (ADDR_IN == `IARP_AW'(`IARP_OFS_POS_BASE + 2 * i + 1)) rd_value = pos_hi_reg[i];
					if (ADDR_IN == `IARP_AW'(`IARP_OFS_SPEED_BASE + i)) rd_value = speed_reg[i];
					if (ADDR_IN == `IARP_AW'(`IARP_OFS_DWELL_BASE + i)) rd_value = dwell_reg[i];
				end
			end
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			RD_DATA_OUT <= '0;
		end else begin
			RD_DATA_OUT <= RD_IN ? rd_value : '0;
		end
	end

	// Input edge detection.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			auto_prev_reg <= 1'b0;
			inc_prev_reg <= 1'b0;
			dec_prev_reg <= 1'b0;
			ret_prev_reg <= 1'b0;
			home_prev_reg <= 1'b0;
			sensor_prev_reg <= 1'b0;
		end else begin
			auto_prev_reg <= AUTO_RUN_IN;
			inc_prev_reg <= INDEX_INC_IN;
			dec_prev_reg <= INDEX_DEC_IN;
			ret_prev_reg <= INDEX_RET_IN;
			home_prev_reg <= HOMING_TRIGGER_IN;
			sensor_prev_reg <= HOME_SENSOR_IN;
		end
	end
	assign auto_rise = AUTO_RUN_IN && !auto_prev_reg;
	assign inc_rise = INDEX_INC_IN && !inc_prev_reg;
	assign dec_rise = INDEX_DEC_IN && !dec_prev_reg;
	assign ret_rise = INDEX_RET_IN && !ret_prev_reg;
	assign home_rise = HOMING_TRIGGER_IN && !home_prev_reg;
	assign sensor_rise = HOME_SENSOR_IN && !sensor_prev_reg;

	assign fault = !ESTOP_NC_IN || !FWD_LIMIT_NC_IN || !REV_LIMIT_NC_IN;
	assign ready = (SERVO_ON_IN || servo_en_reg[0]) && !fault;
	assign mode_ok = (ctrl_mode_reg == `IARP_CTRL_PR_FWD || ctrl_mode_reg == `IARP_CTRL_PR_REV)
		&& (pos_mode_reg == `IARP_POS_AUTO_ABS || pos_mode_reg == `IARP_POS_AUTO_INC);
	assign home_ok = (home_mode_reg == `IARP_HOME_FWD || home_mode_reg == `IARP_HOME_REV)
		&& !MODE_SEL1_IN && MODE_SEL0_IN;
	assign go_next = (dwell_cnt_reg == 16'h0000) && (hold_cnt_reg == 16'h0000) && AUTO_RUN_IN;

	// Sequencer.
	always_comb begin
		state_next = state_reg;
		ptr_next = ptr_reg;
		start_move = 1'b0;
		case (state_reg)
			iarp_pkg::IARP_ALARM: begin
				if (ready) state_next = iarp_pkg::IARP_READY;
			end
			iarp_pkg::IARP_READY, iarp_pkg::IARP_HOMED, iarp_pkg::IARP_INPOS: begin
				if (home_rise && home_ok && state_reg != iarp_pkg::IARP_INPOS) begin
					state_next = iarp_pkg::IARP_HOMING;
				end else if (mode_ok && live != '0) begin
					if (ret_rise) begin
						ptr_next = find_point('0, 1'b0, 1'b1, live);
						start_move = 1'b1;
					end else if (inc_rise) begin
						ptr_next = find_point(ptr_reg, 1'b0, 1'b0, live);
						start_move = 1'b1;
					end else if (dec_rise) begin
						ptr_next = find_point(ptr_reg, 1'b1, 1'b0, live);
						start_move = 1'b1;
					end else if (auto_rise && state_reg != iarp_pkg::IARP_INPOS) begin
						ptr_next = find_point(ptr_reg, 1'b0, 1'b1, live);
						start_move = 1'b1;
					end else if (state_reg == iarp_pkg::IARP_INPOS && go_next) begin
						ptr_next = find_point(ptr_reg, 1'b0, 1'b0, live);
						start_move = 1'b1;
					end
					if (start_move) state_next = iarp_pkg::IARP_CHANGE;
				end
			end
			iarp_pkg::IARP_HOMING: begin
				if (sensor_rise) state_next = iarp_pkg::IARP_HOMED;
			end
			iarp_pkg::IARP_CHANGE: begin
				if (MOVE_DONE_IN) state_next = iarp_pkg::IARP_INPOS;
			end
			default: state_next = iarp_pkg::IARP_ALARM;
		endcase
		if (!ready) begin
			state_next = iarp_pkg::IARP_ALARM;
			start_move = 1'b0;
			ptr_next = ptr_reg;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_reg <= iarp_pkg::IARP_ALARM;
			ptr_reg <= '0;
		end else begin
			state_reg <= state_next;
			ptr_reg <= ptr_next;
		end
	end

	// Motion command: absolute or accumulated incremental target, geared.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			target_reg <= '0;
			MOVE_START_OUT <= 1'b0;
			CMD_POS_OUT <= '0;
			CMD_SPEED_OUT <= '0;
		end else begin
			MOVE_START_OUT <= start_move;
			if (start_move) begin
				if (pos_mode_reg == `IARP_POS_AUTO_INC) begin
					target_reg <= target_reg + {pos_hi_reg[ptr_next], pos_lo_reg[ptr_next]};
				end else begin
					target_reg <= {pos_hi_reg[ptr_next], pos_lo_reg[ptr_next]};
				end
				CMD_SPEED_OUT <= speed_reg[ptr_next];
			end
			CMD_POS_OUT <= gear_scale(target_reg, gear_num_reg, gear_den_reg);
		end
	end

	// Settings presented to the motion core.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ACCEL_OUT <= '0;
			DECEL_OUT <= '0;
			SHAPING_EN_OUT <= 1'b0;
			TORQUE_REV_OUT <= 1'b0;
			HOME_DIR_REV_OUT <= 1'b0;
			HOME_OFFSET_OUT <= '0;
		end else begin
			SHAPING_EN_OUT <= (scurve_reg != 16'h0000);
			ACCEL_OUT <= (scurve_reg != 16'h0000) ? accel_reg : 16'h0000;
			DECEL_OUT <= (scurve_reg != 16'h0000) ? decel_reg : 16'h0000;
			TORQUE_REV_OUT <= (ctrl_mode_reg == `IARP_CTRL_PR_REV);
			HOME_DIR_REV_OUT <= (home_mode_reg == `IARP_HOME_REV);
			HOME_OFFSET_OUT <= 32'(turns_reg * `IARP_TURN_PULSES) + 32'(pulses_reg);
		end
	end

	// Dwell and hold timers counted in 4 ms ticks.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick ? '0 : TW'(tick_cnt_reg + 1'b1);
		end
	end
	assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			dwell_cnt_reg <= '0;
			hold_cnt_reg <= '0;
		end else if (state_reg == iarp_pkg::IARP_CHANGE && MOVE_DONE_IN) begin
			dwell_cnt_reg <= dwell_reg[ptr_reg];
			hold_cnt_reg <= out_mode_reg[0] ? hold_delay_reg : 16'h0000;
		end else if (tick) begin
			if (dwell_cnt_reg != 16'h0000) dwell_cnt_reg <= dwell_cnt_reg - 16'h0001;
			if (hold_cnt_reg != 16'h0000) hold_cnt_reg <= hold_cnt_reg - 16'h0001;
		end
	end

	// Combination code and output lines.
	always_comb begin
		case (state_reg)
			iarp_pkg::IARP_READY: code = `IARP_CODE_READY;
			iarp_pkg::IARP_HOMING: code = `IARP_CODE_HOMING;
			iarp_pkg::IARP_HOMED: code = `IARP_CODE_HOMED;
			iarp_pkg::IARP_CHANGE: code = `IARP_CODE_CHANGE;
			iarp_pkg::IARP_INPOS: code = `IARP_CODE_INDEX_BASE + 5'(ptr_reg);
			default: code = `IARP_CODE_ALARM;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			STATUS_LINES_OUT <= '0;
		end else begin
			STATUS_LINES_OUT <= out_mode_reg[0] ? code : gp_reg[4:0];
		end
	end

	// Interrupt status: set wins over a clear in the same cycle.
	always_comb begin
		irq_set = '0;
		if (state_next == iarp_pkg::IARP_ALARM && state_reg != iarp_pkg::IARP_ALARM)
			irq_set = irq_set | iarp_pkg::IARP_EV_ALARM;
		if (state_next == iarp_pkg::IARP_HOMED && state_reg == iarp_pkg::IARP_HOMING)
			irq_set = irq_set | iarp_pkg::IARP_EV_HOMED;
		if (state_next == iarp_pkg::IARP_INPOS && state_reg == iarp_pkg::IARP_CHANGE)
			irq_set = irq_set | iarp_pkg::IARP_EV_INPOS;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~((WR_IN && ADDR_IN == `IARP_OFS_IRQ_CLEAR)
				? WR_DATA_IN[2:0] : 3'h0)) | irq_set;
		end
	end
	assign IRQ_OUT = |(irq_status_reg & irq_enable_reg);

	change_code_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		state_reg == iarp_pkg::IARP_CHANGE && out_mode_reg[0] |=> STATUS_LINES_OUT == 5'h04)
		else $error("index change code wrong");
	index_code_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		state_reg == iarp_pkg::IARP_INPOS && out_mode_reg[0] |=>
		STATUS_LINES_OUT == 5'(5'h05 + 5'($past(ptr_reg))))
		else $error("in-position code wrong");
	estop_alarm_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!ESTOP_NC_IN ##1 !ESTOP_NC_IN && out_mode_reg[0] |=> STATUS_LINES_OUT == 5'h00)
		else $error("open stop contact not reported");
	limit_alarm_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!FWD_LIMIT_NC_IN || !REV_LIMIT_NC_IN |=> state_reg == iarp_pkg::IARP_ALARM)
		else $error("open limit contact not an alarm");
	skip_point_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$rose(MOVE_START_OUT) |-> live[ptr_reg])
		else $error("zero dwell point was commanded");
	shaping_off_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		scurve_reg == 16'h0000 ##1 scurve_reg == 16'h0000 |-> ACCEL_OUT == 16'h0000
		&& DECEL_OUT == 16'h0000 && !SHAPING_EN_OUT)
		else $error("shaping active with zero smoothing");
	home_offset_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$stable(turns_reg) && $stable(pulses_reg) |=>
		HOME_OFFSET_OUT == 32'($past(turns_reg)) * `IARP_TURN_PULSES + 32'($past(pulses_reg)))
		else $error("homing offset wrong");
	hold_time_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		state_reg == iarp_pkg::IARP_INPOS && hold_cnt_reg != 16'h0000 && !inc_rise && !dec_rise
		&& !ret_rise |=> state_reg != iarp_pkg::IARP_CHANGE)
		else $error("code left before hold delay");
	homing_enable_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		state_reg != iarp_pkg::IARP_HOMING ##1 state_reg == iarp_pkg::IARP_HOMING |->
		!$past(MODE_SEL1_IN) && $past(MODE_SEL0_IN))
		else $error("homing started with wrong mode select");
endmodule

// ==== dv/iarp_motion_model.sv ====
// Motion core model: answers each step start with a one-cycle done pulse after a set delay.
`timescale 1ns/1ns
module iarp_motion_model (
	input wire logic CLK_IN, // clock
	input wire logic RST_IN, // reset, active high
	input wire logic START_IN, // step start pulse
	input wire logic [7:0] DELAY_IN, // cycles from start to done
	output logic DONE_OUT // done pulse
);
	int cnt;
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cnt <= 0;
			DONE_OUT <= 1'b0;
		end else begin
			DONE_OUT <= (cnt == 1);
			if (START_IN)
				cnt <= int'(DELAY_IN);
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the indexed auto-run positioner.
`timescale 1ns/1ns
`include "iarp_regs.svh"
module tb;
	typedef struct {int sel; logic [31:0] exp; logic [31:0] mask;} iarp_note_t;
	logic CLK_IN = 0, RST_IN = 1, WR_IN = 0, RD_IN = 0, rd_seen = 0;
	logic [11:0] ADDR_IN = 0;
	logic [15:0] WR_DATA_IN = 0, v, w;
	logic SERVO_ON_IN = 1, AUTO_RUN_IN = 0, INC_IN = 0, DEC_IN = 0, RET_IN = 0;
	logic TRIG_IN = 0, SENSOR_IN = 0, SEL0_IN = 0, SEL1_IN = 0, MOVE_DONE_IN;
	logic [2:0] nc = 3'h7;
	logic [7:0] delay = 8'h14;
	logic [15:0] RD_DATA_OUT, CMD_SPEED_OUT, ACCEL_OUT, DECEL_OUT;
	logic [31:0] CMD_POS_OUT, HOME_OFFSET_OUT;
	logic [4:0] STATUS_LINES_OUT;
	logic MOVE_START_OUT, SHAPING_EN_OUT, TORQUE_REV_OUT, HOME_DIR_REV_OUT, IRQ_OUT;
	int num_errors = 0, checks = 0, i;
	iarp_note_t notes[$], n;
	string nm[11] = '{"rd_data", "lines", "irq", "torque_rev", "home_dir_rev", "home_offset",
		"accel", "decel", "shaping", "cmd_pos", "cmd_speed"};
	logic [11:0] ofs[13] = '{12'h101, 12'h121, 12'h122, 12'h123, 12'h124, 12'h12c, 12'h12d,
		12'h12f, 12'h132, 12'h133, 12'h22c, 12'h22d, 12'h233};
	logic [15:0] rv[13] = '{16'h0001, 16'h0005, 0, 0, 0, 16'h0001, 16'h0001, 16'h0202, 0, 0,
		16'h0001, 0, 0};
	always #5 CLK_IN = ~CLK_IN;
	iarp_positioner #(.TICK_CYCLES(4)) i_iarp_positioner (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
		.ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
		.RD_DATA_OUT(RD_DATA_OUT), .SERVO_ON_IN(SERVO_ON_IN), .AUTO_RUN_IN(AUTO_RUN_IN),
		.INDEX_INC_IN(INC_IN), .INDEX_DEC_IN(DEC_IN), .INDEX_RET_IN(RET_IN),
		.HOMING_TRIGGER_IN(TRIG_IN), .HOME_SENSOR_IN(SENSOR_IN), .MODE_SEL0_IN(SEL0_IN),
		.MODE_SEL1_IN(SEL1_IN), .FWD_LIMIT_NC_IN(nc[0]), .REV_LIMIT_NC_IN(nc[1]),
		.ESTOP_NC_IN(nc[2]), .MOVE_DONE_IN(MOVE_DONE_IN), .MOVE_START_OUT(MOVE_START_OUT),
		.CMD_POS_OUT(CMD_POS_OUT), .CMD_SPEED_OUT(CMD_SPEED_OUT), .ACCEL_OUT(ACCEL_OUT),
		.DECEL_OUT(DECEL_OUT), .SHAPING_EN_OUT(SHAPING_EN_OUT), .TORQUE_REV_OUT(TORQUE_REV_OUT),
		.HOME_DIR_REV_OUT(HOME_DIR_REV_OUT), .HOME_OFFSET_OUT(HOME_OFFSET_OUT),
		.STATUS_LINES_OUT(STATUS_LINES_OUT), .IRQ_OUT(IRQ_OUT));
	iarp_motion_model i_iarp_motion_model (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
		.START_IN(MOVE_START_OUT), .DELAY_IN(delay), .DONE_OUT(MOVE_DONE_IN));
	function logic [31:0] pick(input int s);
		case (s)
			0: return {16'h0, RD_DATA_OUT};
			1: return {27'h0, STATUS_LINES_OUT};
			2: return {31'h0, IRQ_OUT};
			3: return {31'h0, TORQUE_REV_OUT};
			4: return {31'h0, HOME_DIR_REV_OUT};
			5: return HOME_OFFSET_OUT;
			6: return {16'h0, ACCEL_OUT};
			7: return {16'h0, DECEL_OUT};
			8: return {31'h0, SHAPING_EN_OUT};
			9: return CMD_POS_OUT;
			default: return {16'h0, CMD_SPEED_OUT};
		endcase
	endfunction
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Each read notes what is expected; the monitor compares in the cycle the data stands.
	always @(posedge CLK_IN) rd_seen <= RD_IN;
	always @(negedge CLK_IN) begin
		if (rd_seen) begin
			n = notes.pop_front();
			check(nm[n.sel], pick(n.sel) & n.mask, n.exp);
		end
	end
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge CLK_IN);
		ADDR_IN <= a;
		WR_DATA_IN <= d;
		WR_IN <= 1'b1;
		@(posedge CLK_IN);
		WR_IN <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input int s = 0,
		input logic [31:0] m = 32'hffffffff);
		@(posedge CLK_IN);
		ADDR_IN <= a;
		RD_IN <= 1'b1;
		notes.push_back('{s, e, m});
		@(posedge CLK_IN);
		RD_IN <= 1'b0;
	endtask
	task chk(input int s, input logic [31:0] e);
		rd(12'h303, e, s);
	endtask
	// Outputs are looked at on the falling edge, away from the edge that launches them.
	task wait_lines(input logic [4:0] c);
		for (int k = 0; k < 300; k++) begin
			@(negedge CLK_IN);
			if (STATUS_LINES_OUT === c) break;
		end
		if (STATUS_LINES_OUT !== c) num_errors++;
		@(posedge CLK_IN);
	endtask
	task wait_start;
		for (int k = 0; k < 300; k++) begin
			@(negedge CLK_IN);
			if (MOVE_START_OUT === 1'b1) break;
		end
		if (MOVE_START_OUT !== 1'b1) num_errors++;
		@(posedge CLK_IN);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		close_out();
	end
	initial begin
		void'($urandom(32'he996));
		repeat (10) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		for (i = 0; i < 13; i++) rd(ofs[i], {16'h0, rv[i]});
		chk(1, 1);
		wr(12'h3ff, 16'hffff);
		rd(12'h3ff, 0);
		for (i = 0; i < 13; i++) begin
			v = 16'($urandom);
			wr(ofs[i], v);
			rd(ofs[i], {16'h0, v});
			wr(ofs[i], rv[i]);
		end
		$display("done: reset values and access");
		wr(`IARP_OFS_CTRL_MODE, `IARP_CTRL_PR_REV);
		chk(3, 1);
		wr(`IARP_OFS_CTRL_MODE, `IARP_CTRL_PR_FWD);
		chk(3, 0);
		wr(`IARP_OFS_HOME_MODE, `IARP_HOME_REV);
		chk(4, 1);
		v = 16'($urandom);
		wr(`IARP_OFS_HOME_TURNS, 16'h0003);
		wr(`IARP_OFS_HOME_PULSES, v);
		chk(5, 32'd30000 + {16'h0, v});
		wr(`IARP_OFS_ACCEL, 16'h0123);
		wr(`IARP_OFS_DECEL, 16'h0456);
		chk(6, 0);
		chk(8, 0);
		wr(`IARP_OFS_SCURVE, 16'h0001);
		chk(6, 32'h0123);
		chk(7, 32'h0456);
		chk(8, 1);
		$display("done: settings");
		w = 16'($urandom) & 16'h7fff;
		wr(`IARP_OFS_POS_BASE + 12'h002, w);
		wr(`IARP_OFS_POS_BASE + 12'h003, w);
		wr(`IARP_OFS_GEAR_NUM, 16'h0002);
		v = 16'($urandom);
		wr(`IARP_OFS_SPEED_BASE + 12'h001, v);
		wr(`IARP_OFS_DWELL_BASE + 12'h001, 16'h0001);
		wr(`IARP_OFS_DWELL_BASE + 12'h002, 16'h0001);
		wr(`IARP_OFS_IRQ_ENABLE, 16'h0004);
		wr(`IARP_OFS_IRQ_CLEAR, 16'h0007);
		@(posedge CLK_IN) AUTO_RUN_IN <= 1'b1;
		wait_start();
		AUTO_RUN_IN <= 1'b0;
		chk(1, 4);
		chk(10, {16'h0, v});
		chk(9, {w, w} << 1);
		wait_lines(6);
		chk(1, 6);
		rd(`IARP_OFS_IRQ_STATUS, 4, 0, 4);
		chk(2, 1);
		wr(`IARP_OFS_IRQ_ENABLE, 16'h0000);
		chk(2, 0);
		wr(`IARP_OFS_IRQ_ENABLE, 16'h0004);
		wr(`IARP_OFS_IRQ_CLEAR, 16'h0004);
		chk(2, 0);
		delay <= 8'h01;
		for (i = 0; i < 4; i++) begin
			@(posedge CLK_IN) {RET_IN, DEC_IN, INC_IN} <= (i == 1) ? 3'b100 : {1'b0, i == 2, i != 2};
			@(posedge CLK_IN) {RET_IN, DEC_IN, INC_IN} <= 3'b000;
			wait_lines(i[0] ? 5'h06 : 5'h07);
			chk(1, i[0] ? 6 : 7);
		end
		$display("done: auto run and steps");
		for (i = 0; i < 3; i++) begin
			@(posedge CLK_IN) nc[i] <= 1'b0;
			wait_lines(0);
			chk(1, 0);
			@(posedge CLK_IN) nc[i] <= 1'b1;
			wait_lines(1);
			chk(1, 1);
		end
		$display("done: limits and stop");
		@(posedge CLK_IN) {SEL1_IN, SEL0_IN, TRIG_IN} <= 3'b111;
		@(posedge CLK_IN) TRIG_IN <= 1'b0;
		repeat (5) @(posedge CLK_IN);
		chk(1, 1);
		@(posedge CLK_IN) {SEL1_IN, TRIG_IN} <= 2'b01;
		@(posedge CLK_IN) TRIG_IN <= 1'b0;
		wait_lines(2);
		chk(1, 2);
		@(posedge CLK_IN) SENSOR_IN <= 1'b1;
		wait_lines(3);
		chk(1, 3);
		rd(`IARP_OFS_IRQ_STATUS, 3, 0, 3);
		$display("done: homing");
		wr(`IARP_OFS_OUT_MODE, 16'h0000);
		v = 16'($urandom);
		wr(`IARP_OFS_GP_OUT, v);
		chk(1, {27'h0, v[4:0]});
		wr(`IARP_OFS_OUT_MODE, 16'h0001);
		chk(1, 3);
		wr(`IARP_OFS_POS_MODE, 16'h0000);
		@(posedge CLK_IN) AUTO_RUN_IN <= 1'b1;
		repeat (10) @(posedge CLK_IN);
		chk(1, 3);
		AUTO_RUN_IN <= 1'b0;
		wr(`IARP_OFS_POS_MODE, `IARP_POS_AUTO_INC);
		wr(`IARP_OFS_HOLD_DELAY, 16'h0003);
		@(posedge CLK_IN) AUTO_RUN_IN <= 1'b1;
		wait_lines(6);
		chk(9, {w, w} << 2);
		chk(1, 6);
		wait_lines(7);
		chk(1, 7);
		AUTO_RUN_IN <= 1'b0;
		$display("done: output and position modes");
		repeat (3) @(posedge CLK_IN);
		close_out();
	end
endmodule
